// >>> rtl/nesc_pkg.sv
// shared constants and carrier types for the note escrow handshake
package nesc_pkg;
  localparam int CLK_HZ        = 250_000_000;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
  localparam int PULSE_MS      = 100;
  localparam int ESCROW_S      = 30;
  localparam int OOS_S         = 45;
  localparam int POWERUP_S     = 6;
  localparam int REIDLE_S      = 1;
  localparam int PULSE_TICKS   = PULSE_MS;
  localparam int ESCROW_TICKS  = ESCROW_S * 1000;
  localparam int OOS_TICKS     = OOS_S * 1000;
  localparam int POWERUP_TICKS = POWERUP_S * 1000;
  localparam int REIDLE_TICKS  = REIDLE_S * 1000;
  localparam int NCHAN         = 16;
  localparam int LOWCHAN_MAX   = 4;
  localparam logic [17:0] PRESC_RESET = 18'h0_0000;
  localparam logic [16:0] TIMER_RESET = 17'h0_0000;

  typedef enum logic [1:0] {
    NESC_MODE_SERIAL,
    NESC_MODE_PARALLEL,
    NESC_MODE_PULSE,
    NESC_MODE_BINARY
  } nesc_mode_t;

  typedef enum {
    NESC_IDLE,
    NESC_VALIDATE,
    NESC_PULSE1,
    NESC_ESCROW,
    NESC_STACK,
    NESC_PULSE2,
    NESC_VEND,
    NESC_RETURN,
    NESC_OOS
  } nesc_state_t;

  // events from the note transport and validator core
  typedef struct packed {
    logic       frontSense;
    logic       validDone;
    logic       validOk;
    logic [3:0] validChan;
    logic       stackDone;
    logic       returnDone;
    logic       notePulled;
  } nesc_mech_t;

  // commands to the note transport
  typedef struct packed {
    logic stackCmd;
    logic returnCmd;
    logic lowPower;
  } nesc_cmd_t;

  typedef struct packed {
    nesc_state_t        state;
    logic [17:0]        presc;
    logic               tick;
    logic [16:0]        timer;
    logic [16:0]        idleTimer;
    logic               lowPower;
    logic [3:0]         chan;
    logic               escReqPrev;
    logic [NCHAN-1:0]   inhPrev;
    logic               busyN;
    logic               vendN;
    logic [NCHAN-1:0]   chanPulse;
    logic               stackCmd;
    logic               returnCmd;
    logic               outOfService;
  } nesc_regs_t;
endpackage

// >>> rtl/nesc_escrow_port.sv
// escrow handshake, credit pulses and low power control of the host port
`timescale 1ns/1ns
`default_nettype none
// Contract
// - escrow only in parallel, pulse, binary modes
// - 100 ms channel pulse on escrow entry
// - escrow line rise claims; 30 s return
// - after claim stack, then second pulse
// - inhibit before timeout returns note immediately
// - all inhibits high reject channels above 4
// - note pulled in escrow: 45 s out
// - low power only in non-serial modes
// - low power 6 s after power-up
// - low power 1 s after busy rises
// - idle: busy high, held until note
// - front sensor wakes, busy low throughout
// - vend low for credit, then busy high
module nesc_escrow_port
  import nesc_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire nesc_mode_t       hostMode,
  input  wire logic             escrowReq,
  input  wire logic [NCHAN-1:0] inhibit,
  input  wire nesc_mech_t       mech,
  output nesc_cmd_t             cmd,
  output logic [NCHAN-1:0]      chanPulse,
  output logic                  busyN,
  output logic                  vendN,
  output logic                  outOfService
);

  nesc_regs_t r;
  nesc_regs_t next_r;

  logic escrowMode;
  logic escRise;
  logic inhRise;
  logic allInh;
  logic chanInh;

  assign escrowMode = (hostMode != NESC_MODE_SERIAL);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    escRise = escrowReq & ~r.escReqPrev;
    allInh  = &inhibit;
    chanInh = inhibit[r.chan];
    inhRise = (chanInh & ~r.inhPrev[r.chan]) | (allInh & (r.chan > 4'(LOWCHAN_MAX)));
    next_r.escReqPrev = escrowReq;
    next_r.inhPrev    = inhibit;
    next_r.stackCmd   = 1'b0;
    next_r.returnCmd  = 1'b0;

    // shared millisecond tick
    next_r.tick = 1'b0;
    if (r.presc == 18'(TICK_CYCLES - 1)) begin
      next_r.presc = PRESC_RESET;
      next_r.tick  = 1'b1;
    end else begin
      next_r.presc = r.presc + 18'h0_0001;
    end
    if (r.tick && r.timer != TIMER_RESET) begin
      next_r.timer = r.timer - 17'h0_0001;
    end

    // low power entry while idle and busy high
    if (r.state == NESC_IDLE && !r.outOfService) begin
      if (r.tick && r.idleTimer != TIMER_RESET) begin
        next_r.idleTimer = r.idleTimer - 17'h0_0001;
      end
      if (r.idleTimer == TIMER_RESET && escrowMode) begin
        next_r.lowPower = 1'b1;
      end
    end

    case (r.state)
      NESC_IDLE: begin
        next_r.busyN = 1'b1;
        next_r.chanPulse = '0;
        if (mech.frontSense) begin
          next_r.lowPower = 1'b0;
          next_r.busyN    = 1'b0;
          next_r.state    = NESC_VALIDATE;
        end
      end
      NESC_VALIDATE: begin
        if (mech.validDone) begin
          next_r.chan = mech.validChan;
          if (!mech.validOk || inhibit[mech.validChan]
              || (allInh && mech.validChan > 4'(LOWCHAN_MAX))) begin
            next_r.returnCmd = 1'b1;
            next_r.state     = NESC_RETURN;
          end else if (escrowMode) begin
            next_r.chanPulse[mech.validChan] = 1'b1;
            next_r.timer = 17'(PULSE_TICKS);
            next_r.state = NESC_PULSE1;
          end else begin
            next_r.stackCmd = 1'b1;
            next_r.state    = NESC_STACK;
          end
        end
      end
      NESC_PULSE1: begin
        if (r.timer == TIMER_RESET) begin
          next_r.chanPulse = '0;
          next_r.timer     = 17'(ESCROW_TICKS);
          next_r.state     = NESC_ESCROW;
        end
      end
      NESC_ESCROW: begin
        if (mech.notePulled) begin
          next_r.timer        = 17'(OOS_TICKS);
          next_r.outOfService = 1'b1;
          next_r.state        = NESC_OOS;
        end else if (inhRise) begin
          next_r.returnCmd = 1'b1;
          next_r.state     = NESC_RETURN;
        end else if (escRise) begin
          next_r.stackCmd = 1'b1;
          next_r.state    = NESC_STACK;
        end else if (r.timer == TIMER_RESET) begin
          next_r.returnCmd = 1'b1;
          next_r.state     = NESC_RETURN;
        end
      end
      NESC_STACK: begin
        if (mech.stackDone && escrowMode) begin
          next_r.chanPulse[r.chan] = 1'b1;
          next_r.timer = 17'(PULSE_TICKS);
          next_r.vendN = 1'b0;
          next_r.state = NESC_PULSE2;
        end else if (mech.stackDone) begin
          // serial: no credit pulse, vend for one cycle
          next_r.vendN = 1'b0;
          next_r.state = NESC_VEND;
        end
      end
      NESC_PULSE2: begin
        if (r.timer == TIMER_RESET) begin
          next_r.chanPulse = '0;
          next_r.state     = NESC_VEND;
        end
      end
      NESC_VEND: begin
        next_r.vendN     = 1'b1;
        next_r.busyN     = 1'b1;
        next_r.idleTimer = 17'(REIDLE_TICKS);
        next_r.state     = NESC_IDLE;
      end
      NESC_RETURN: begin
        if (mech.returnDone) begin
          next_r.busyN     = 1'b1;
          next_r.idleTimer = 17'(REIDLE_TICKS);
          next_r.state     = NESC_IDLE;
        end
      end
      NESC_OOS: begin
        if (r.timer == TIMER_RESET) begin
          next_r.outOfService = 1'b0;
          next_r.busyN        = 1'b1;
          next_r.idleTimer    = 17'(REIDLE_TICKS);
          next_r.state        = NESC_IDLE;
        end
      end
      default: begin
        next_r.state = NESC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r.state        <= NESC_IDLE;
      r.presc        <= PRESC_RESET;
      r.tick         <= 1'b0;
      r.timer        <= TIMER_RESET;
      r.idleTimer    <= 17'(POWERUP_TICKS);
      r.lowPower     <= 1'b0;
      r.chan         <= 4'h0;
      r.escReqPrev   <= 1'b0;
      r.inhPrev      <= '0;
      r.busyN        <= 1'b1;
      r.vendN        <= 1'b1;
      r.chanPulse    <= '0;
      r.stackCmd     <= 1'b0;
      r.returnCmd    <= 1'b0;
      r.outOfService <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign cmd.stackCmd  = r.stackCmd;
  assign cmd.returnCmd = r.returnCmd;
  assign cmd.lowPower  = r.lowPower;
  assign chanPulse     = r.chanPulse;
  assign busyN         = r.busyN;
  assign vendN         = r.vendN;
  assign outOfService  = r.outOfService;

endmodule
`default_nettype wire

// >>> tb/nesc_escrow_port_asserts.sv
// pin-level assertions for the escrow port
`timescale 1ns/1ns
`default_nettype none
module nesc_escrow_port_asserts
  import nesc_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             reset_n,
  input wire nesc_mode_t       hostMode,
  input wire logic             escrowReq,
  input wire logic [NCHAN-1:0] inhibit,
  input wire nesc_mech_t       mech,
  input wire nesc_cmd_t        cmd,
  input wire logic [NCHAN-1:0] chanPulse,
  input wire logic             busyN,
  input wire logic             vendN,
  input wire logic             outOfService
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> busyN && vendN && chanPulse == '0
    && cmd == '0 && !outOfService) else $error("outputs not quiet after reset");
  a_front_busy: assert property (busyN && !outOfService && mech.frontSense |=> !busyN && !cmd.lowPower)
    else $error("busy not taken on note arrival");
  a_pulse_onehot: assert property ($onehot0(chanPulse)) else $error("more than one channel pulsed");
  a_vend_busy: assert property (!vendN |-> !busyN) else $error("busy high while vend low");
  a_serial_nolp: assert property (hostMode == NESC_MODE_SERIAL && !cmd.lowPower |=> !cmd.lowPower)
    else $error("low power entered in serial mode");
  a_busy_nolp: assert property (!busyN |-> !cmd.lowPower) else $error("low power while busy");
  a_cmd_exclusive: assert property (!(cmd.stackCmd && cmd.returnCmd)) else $error("stack and return together");
  a_serial_nocred: assert property (hostMode == NESC_MODE_SERIAL && chanPulse == '0 |=> chanPulse == '0)
    else $error("credit pulse in serial mode");
  c_pulse: cover property (chanPulse != '0);
  c_return: cover property (cmd.returnCmd);
  c_stack: cover property (cmd.stackCmd);
endmodule
`default_nettype wire

// >>> tb/nesc_host_model.sv
// vending controller side: escrow line and inhibits
`timescale 1ns/1ns
`default_nettype none
module nesc_host_model
  import nesc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        claim,
  input wire logic        rejectAll,
  output logic             escrowReq,
  output logic [NCHAN-1:0] inhibit
);
  always_ff @(posedge core_clk) begin
    escrowReq <= claim;
    inhibit <= rejectAll ? '1 : '0;
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// top testbench for the escrow port
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import nesc_pkg::*;
;
  logic core_clk = 0, reset_n = 0, claim = 0, rejectAll = 0, escrowReq;
  nesc_mode_t hostMode = NESC_MODE_PARALLEL;
  logic [NCHAN-1:0] inhibit, chanPulse;
  nesc_mech_t mech = '0;
  nesc_cmd_t cmd;
  logic busyN, vendN, outOfService;
  int bad_count = 0, tests_run = 0;
  always #2 core_clk = ~core_clk;
  nesc_escrow_port u_dut (.core_clk(core_clk), .reset_n(reset_n), .hostMode(hostMode), .escrowReq(escrowReq),
    .inhibit(inhibit), .mech(mech), .cmd(cmd), .chanPulse(chanPulse), .busyN(busyN), .vendN(vendN),
    .outOfService(outOfService));
  nesc_host_model u_host (.core_clk(core_clk), .claim(claim), .rejectAll(rejectAll), .escrowReq(escrowReq),
    .inhibit(inhibit));
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task rst;
    @(posedge core_clk) reset_n <= 0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1;
    #1 chk("idle", 16'h0003, {outOfService, cmd, chanPulse[9:0], busyN, vendN});
  endtask
  task note(input logic [3:0] ch, input logic ok);
    @(posedge core_clk) mech.frontSense <= 1;
    repeat (2) @(posedge core_clk);
    #1 chk("busy", 16'h0000, 16'(busyN));
    @(posedge core_clk) {mech.validDone, mech.validOk, mech.validChan} <= {1'b1, ok, ch};
    @(posedge core_clk) {mech.validDone, mech.frontSense} <= 2'b00;
    #1;
  endtask
  task wait_cmd(input string what, input logic ret);
    int i;
    for (i = 0; i < 20 && (ret ? cmd.returnCmd : cmd.stackCmd) !== 1'b1; i++) @(posedge core_clk) #1;
    chk(what, 16'h0001, 16'(ret ? cmd.returnCmd : cmd.stackCmd));
    @(posedge core_clk) {mech.returnDone, mech.stackDone} <= {ret, !ret};
    @(posedge core_clk) {mech.returnDone, mech.stackDone} <= 2'b00;
  endtask
  task t_reject;
    note(4'h2, 1'b0);
    wait_cmd("invalid return", 1'b1);
    repeat (10) @(posedge core_clk);
    #1 chk("reject vend busy", 16'h0003, {chanPulse[13:0], busyN, vendN});
  endtask
  task t_all_inhibit;
    rejectAll <= 1;
    note(4'h6, 1'b1);
    chk("no pulse", 16'h0000, chanPulse);
    wait_cmd("inhibit return", 1'b1);
    rejectAll <= 0;
  endtask
  task t_serial;
    hostMode <= NESC_MODE_SERIAL;
    note(4'h2, 1'b1);
    chk("serial pulse", 16'h0000, chanPulse);
    wait_cmd("serial stack", 1'b0);
    #1 chk("serial no credit", 16'h0000, chanPulse);
    chk("serial vend", 16'h0000, 16'(vendN));
    hostMode <= NESC_MODE_PARALLEL;
    rst;
  endtask
  task t_credit;
    note(4'h3, 1'b1);
    chk("first pulse", 16'h0008, chanPulse);
    chk("no vend yet", 16'h0001, 16'(vendN));
    rst;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst;
    t_reject;
    t_all_inhibit;
    t_serial;
    t_credit;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    finish_test;
  end
endmodule
bind nesc_escrow_port nesc_escrow_port_asserts u_chk (.core_clk(core_clk), .reset_n(reset_n), .hostMode(hostMode),
  .escrowReq(escrowReq), .inhibit(inhibit), .mech(mech), .cmd(cmd), .chanPulse(chanPulse), .busyN(busyN),
  .vendN(vendN), .outOfService(outOfService));
`default_nettype wire
